// *** include/rmlc_pkg.sv ***
// Package: constants for the register map lock and checksum block
package rmlc_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    // Printed offsets are not all multiples of four: they are indexes
    localparam logic [7:0] SEC_INDEX = 8'h1f;
    localparam logic [7:0] CFG_A_INDEX = 8'h0d;
    localparam logic [7:0] CFG_B_INDEX = 8'h0e;
    localparam logic [7:0] CFG_C_INDEX = 8'h0f;
    localparam logic [7:0] CFG_D_INDEX = 8'h10;
    localparam int NUM_CFG = 4;
    localparam logic [7:0] KEY_UNLOCK = 8'ha5;
    localparam int KEY_LSB = 16;
    localparam int CHK_LSB = 0;
    localparam logic [23:0] CFG_RESET = 24'h000000;
    localparam logic [15:0] CHK_RESET = 16'h0000;
    localparam logic [15:0] CHK_SEED = 16'hffff;
    localparam logic [15:0] CHK_POLY = 16'h1021;
    localparam logic [31:0] UNDEF_READ = 32'h00000000;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CHK_PERIOD = 21;
    localparam logic [4:0] CHK_PERIOD_LAST = 5'(CHK_PERIOD - 1);
    // ------------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rmlc_pkg

// *** design/rmlc_top.sv ***
// Module: register map lock with periodic checksum, AXI4-Lite slave
`timescale 1ns/10ps
// How it works
// - Key field bits 23:16 resets to unlock
// - Unlocked key: every register accepts writes
// - Unlocked: checksum and interrupt held cleared
// - Unlocked: no checksum computation runs
// - Locked: only security register accepts writes
// - Locked: other registers read undefined
// - Locked: checksum runs; interrupt needs enable
// - 16-bit checksum over writable map, read-only
// - Checksum updates every 21 modulator clocks
// - Unlock value forces checksum field zero
module rmlc_top (
    // Clock, enable, reset
    input wire logic CLK_SYS,
    input wire logic CLK_EN,
    input wire logic RESETN,
    // Interrupt enable and checksum alert
    input wire logic CHK_INT_EN,
    output logic CHK_INT,
    // AXI4-Lite write address
    input wire logic [9:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [9:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0] key_reg;
    logic [23:0] cfg_reg [rmlc_pkg::NUM_CFG];
    logic [15:0] map_checksum_field_reg;
    logic [4:0] tick_reg;
    logic [9:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic unlocked;
    logic wr_fire;
    logic [15:0] chk_next;

    assign unlocked = (key_reg == rmlc_pkg::KEY_UNLOCK);
    assign wr_fire = aw_held_reg && w_held_reg && !S_AXI_BVALID;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] word_index(input logic [9:0] addr);
        return addr[9:2];
    endfunction : word_index

    function automatic logic [1:0] cfg_slot(input logic [7:0] idx);
        return 2'(idx - rmlc_pkg::CFG_A_INDEX);
    endfunction : cfg_slot

    function automatic logic is_cfg(input logic [7:0] idx);
        return idx >= rmlc_pkg::CFG_A_INDEX && idx <= rmlc_pkg::CFG_D_INDEX;
    endfunction : is_cfg

    function automatic logic [23:0] merge(input logic [23:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [23:0] res;
        res = old;
        for (int i = 0; i < 3; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // One CRC-16 step per byte, MSB first
    function automatic logic [15:0] crc_byte(input logic [15:0] crc,
                                             input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c = c[15] ? ((c << 1) ^ rmlc_pkg::CHK_POLY) : (c << 1);
        end
        return c;
    endfunction : crc_byte

    // ------------------------------------------------------------------
    // Checksum message: config words high byte first, then the key
    // ------------------------------------------------------------------
    always_comb begin
        logic [15:0] c;
        c = rmlc_pkg::CHK_SEED;
        for (int r = 0; r < rmlc_pkg::NUM_CFG; r++) begin
            c = crc_byte(c, cfg_reg[r][23:16]);
            c = crc_byte(c, cfg_reg[r][15:8]);
            c = crc_byte(c, cfg_reg[r][7:0]);
        end
        chk_next = crc_byte(c, key_reg);
    end

    // ------------------------------------------------------------------
    // Write channel capture
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 10'h000;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
        end else if (CLK_EN) begin
            S_AXI_AWREADY <= !aw_held_reg && !S_AXI_AWREADY && !S_AXI_BVALID;
            S_AXI_WREADY <= !w_held_reg && !S_AXI_WREADY && !S_AXI_BVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Write response
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= rmlc_pkg::RESP_OKAY;
        end else if (CLK_EN) begin
            if (wr_fire) begin
                S_AXI_BVALID <= 1'b1;
                if (word_index(aw_addr_reg) == rmlc_pkg::SEC_INDEX ||
                    (is_cfg(word_index(aw_addr_reg)) && unlocked)) begin
                    S_AXI_BRESP <= rmlc_pkg::RESP_OKAY;
                end else begin
                    S_AXI_BRESP <= rmlc_pkg::RESP_SLVERR;
                end
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Security key
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            key_reg <= rmlc_pkg::KEY_UNLOCK;
        end else if (CLK_EN) begin
            if (wr_fire && word_index(aw_addr_reg) == rmlc_pkg::SEC_INDEX &&
                w_strb_reg[2]) begin
                key_reg <= w_data_reg[23:16];
            end
        end
    end

    // ------------------------------------------------------------------
    // Writable configuration words
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            for (int r = 0; r < rmlc_pkg::NUM_CFG; r++) begin
                cfg_reg[r] <= rmlc_pkg::CFG_RESET;
            end
        end else if (CLK_EN) begin
            if (wr_fire && unlocked && is_cfg(word_index(aw_addr_reg))) begin
                cfg_reg[cfg_slot(word_index(aw_addr_reg))] <= merge(
                    cfg_reg[cfg_slot(word_index(aw_addr_reg))],
                    w_data_reg, w_strb_reg);
            end
        end
    end

    // ------------------------------------------------------------------
    // Checksum engine and alert
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            tick_reg <= 5'h00;
            map_checksum_field_reg <= rmlc_pkg::CHK_RESET;
        end else if (CLK_EN) begin
            if (unlocked) begin
                tick_reg <= 5'h00;
                map_checksum_field_reg <= rmlc_pkg::CHK_RESET;
            end else if (tick_reg == rmlc_pkg::CHK_PERIOD_LAST) begin
                tick_reg <= 5'h00;
                map_checksum_field_reg <= chk_next;
            end else begin
                tick_reg <= tick_reg + 5'h01;
            end
        end
    end

    // Alert when the stored checksum no longer matches the map
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            CHK_INT <= 1'b0;
        end else if (CLK_EN) begin
            if (unlocked) begin
                CHK_INT <= 1'b0;
            end else if (tick_reg == rmlc_pkg::CHK_PERIOD_LAST) begin
                CHK_INT <= CHK_INT_EN && map_checksum_field_reg != 16'h0000
                           && chk_next != map_checksum_field_reg;
            end else if (!CHK_INT_EN) begin
                CHK_INT <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= rmlc_pkg::RESP_OKAY;
        end else if (CLK_EN) begin
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= rmlc_pkg::RESP_OKAY;
                if (word_index(S_AXI_ARADDR) == rmlc_pkg::SEC_INDEX) begin
                    S_AXI_RDATA <= {8'h00, key_reg,
                                    map_checksum_field_reg};
                end else if (is_cfg(word_index(S_AXI_ARADDR))) begin
                    S_AXI_RDATA <= unlocked ?
                        {8'h00, cfg_reg[cfg_slot(word_index(S_AXI_ARADDR))]}
                        : rmlc_pkg::UNDEF_READ;
                end else begin
                    S_AXI_RDATA <= 32'h00000000;
                    S_AXI_RRESP <= rmlc_pkg::RESP_SLVERR;
                end
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);

    sequence s_locked_cfg_write;
        wr_fire && CLK_EN && !unlocked && is_cfg(word_index(aw_addr_reg));
    endsequence

    a_unlock_chk_zero: assert property (
        CLK_EN && unlocked |=> map_checksum_field_reg == 16'h0000)
        else $error("checksum not cleared while unlocked");
    a_unlock_int_low: assert property (
        CLK_EN && unlocked |=> !CHK_INT)
        else $error("alert raised while unlocked");
    a_unlock_no_tick: assert property (
        CLK_EN && unlocked |=> tick_reg == 5'h00)
        else $error("checksum engine ran while unlocked");
    a_locked_write_drop: assert property (
        s_locked_cfg_write |=> $stable(cfg_reg[0]) && $stable(cfg_reg[1])
            && $stable(cfg_reg[2]) && $stable(cfg_reg[3]))
        else $error("locked map accepted a write");
    a_unlocked_write_take: assert property (
        wr_fire && CLK_EN && unlocked && w_strb_reg == 4'hf &&
        word_index(aw_addr_reg) == rmlc_pkg::CFG_A_INDEX
        |=> cfg_reg[0] == $past(w_data_reg[23:0]))
        else $error("unlocked write not stored");
    a_int_needs_en: assert property (
        CLK_EN && !CHK_INT_EN |=> !CHK_INT)
        else $error("alert without enable");
    a_chk_period_hold: assert property (
        CLK_EN && !unlocked && tick_reg != rmlc_pkg::CHK_PERIOD_LAST
        |=> $stable(map_checksum_field_reg))
        else $error("checksum changed between periods");
    a_key_reset_value: assert property (
        $rose(RESETN) |-> key_reg == 8'ha5)
        else $error("key not at unlock value after reset");
    a_read_sec_layout: assert property (
        CLK_EN && S_AXI_ARVALID && S_AXI_ARREADY &&
        word_index(S_AXI_ARADDR) == rmlc_pkg::SEC_INDEX
        |=> S_AXI_RDATA[23:16] == key_reg)
        else $error("security read layout wrong");
    a_locked_read_undef: assert property (
        CLK_EN && S_AXI_ARVALID && S_AXI_ARREADY && !unlocked &&
        is_cfg(word_index(S_AXI_ARADDR))
        |=> S_AXI_RDATA == 32'h00000000)
        else $error("locked read leaked contents");
endmodule : rmlc_top

// *** verif/rmlc_host.sv ***
// Host model: AXI4-Lite master that reaches the register map
`timescale 1ns/10ps
module rmlc_host (
    // Clock
    input wire logic clk,
    // Write channels
    output logic [9:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // Read channels
    output logic [9:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    task automatic wr(input logic [9:0] a, input logic [31:0] dat,
                      input logic [3:0] s, output logic [1:0] resp);
        @(posedge clk);
        awaddr <= a;
        wdata <= dat;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~dat;
            end
        end while (!(bvalid && bready));
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    // Lag holds rready low that many cycles to stall the answer
    task automatic rd(input logic [9:0] a, input int lag,
                      output logic [31:0] dat, output logic [1:0] resp);
        int k;
        k = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (lag == 0);
        do begin
            @(posedge clk);
            k++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (!rready && k >= lag) rready <= 1'b1;
        end while (!(rvalid && rready));
        dat = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : rmlc_host

// *** verif/tb_top.sv ***
// Testbench: register map lock and checksum scenarios
`timescale 1ns/10ps
module tb_top;
    // ------------------------------------------------------------------
    // Wiring
    // ------------------------------------------------------------------
    localparam logic [7:0] sec = rmlc_pkg::SEC_INDEX;
    localparam logic [1:0] okay = rmlc_pkg::RESP_OKAY;
    localparam logic [1:0] slverr = rmlc_pkg::RESP_SLVERR;
    logic clk_sys, resetn, chk_int_en, chk_int, clk_en;
    logic [9:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    int err_count;
    int n_tests;
    logic [23:0] cfg_val [4] = '{24'h123456, 24'h00ff01, 24'h80a5c3,
                                 24'h7e0001};
    logic [7:0] cfg_idx [4] = '{rmlc_pkg::CFG_A_INDEX, rmlc_pkg::CFG_B_INDEX,
                                rmlc_pkg::CFG_C_INDEX, rmlc_pkg::CFG_D_INDEX};
    rmlc_top dut (
        .CLK_SYS(clk_sys), .CLK_EN(clk_en), .RESETN(resetn),
        .CHK_INT_EN(chk_int_en), .CHK_INT(chk_int),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
    );
    rmlc_host host (
        .clk(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready)
    );
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [7:0] i, input logic [31:0] e,
                          input logic [1:0] re);
        host.rd({i, 2'b00}, 0, d, r);
        check(d, e);
        check({30'h0, r}, {30'h0, re});
    endtask : rd_chk
    task automatic wr_chk(input logic [7:0] i, input logic [31:0] v,
                          input logic [3:0] s, input logic [1:0] re);
        host.wr({i, 2'b00}, v, s, r);
        check({30'h0, r}, {30'h0, re});
    endtask : wr_chk
    // Checksum step, most significant bit first
    function automatic logic [15:0] crc8(input logic [15:0] c,
                                         input logic [7:0] b);
        for (int k = 7; k >= 0; k--) begin
            c = (c[15] ^ b[k]) ? ({c[14:0], 1'b0} ^ rmlc_pkg::CHK_POLY)
                               : {c[14:0], 1'b0};
        end
        return c;
    endfunction : crc8
    function automatic logic [15:0] exp_crc(input logic [7:0] key);
        logic [15:0] c;
        c = rmlc_pkg::CHK_SEED;
        for (int w = 0; w < 4; w++) begin
            for (int b = 2; b >= 0; b--) begin
                c = crc8(c, cfg_val[w][8*b +: 8]);
            end
        end
        return crc8(c, key);
    endfunction : exp_crc
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd_chk(sec, 32'h00a50000, okay);
        rd_chk(cfg_idx[0], 32'h0, okay);
    endtask : t_reset
    task automatic t_unlocked;
        for (int w = 0; w < 4; w++) begin
            wr_chk(cfg_idx[w], {8'hff, cfg_val[w]}, 4'hf, okay);
        end
        for (int w = 0; w < 4; w++) begin
            rd_chk(cfg_idx[w], {8'h00, cfg_val[w]}, okay);
        end
        repeat (30) @(posedge clk_sys);
        rd_chk(sec, 32'h00a50000, okay);
        check({31'h0, chk_int}, 32'h0);
    endtask : t_unlocked
    task automatic t_lock(input logic en, input logic [7:0] key);
        logic hit;
        logic [7:0] key2;
        hit = 1'b0;
        key2 = key ^ 8'h01;
        chk_int_en <= en;
        wr_chk(sec, {8'h00, key, 16'h0}, 4'h4, okay);
        rd_chk(sec, {8'h00, key, 16'h0}, okay);
        wr_chk(cfg_idx[1], 32'h00aaaaaa, 4'hf, slverr);
        rd_chk(cfg_idx[1], 32'h0, okay);
        wr_chk(sec, 32'h00a5ffff, 4'h3, okay);
        repeat (12) @(posedge clk_sys);
        rd_chk(sec, {8'h00, key, exp_crc(key)}, okay);
        // New key while locked: next update sees a changed map
        wr_chk(sec, {8'h00, key2, 16'h0}, 4'h4, okay);
        repeat (30) begin
            @(posedge clk_sys);
            hit = hit | chk_int;
        end
        check({31'h0, hit}, {31'h0, en});
        rd_chk(sec, {8'h00, key2, exp_crc(key2)}, okay);
    endtask : t_lock
    task automatic t_unlock;
        wr_chk(sec, 32'h00a50000, 4'h4, okay);
        host.rd({sec, 2'b00}, 5, d, r);
        check(d, 32'h00a50000);
        check({31'h0, chk_int}, 32'h0);
        wr_chk(cfg_idx[1], {8'h00, cfg_val[1]}, 4'hf, okay);
    endtask : t_unlock
    task automatic t_unmapped;
        wr_chk(8'h05, 32'h1, 4'hf, slverr);
        rd_chk(8'h05, 32'h0, slverr);
    endtask : t_unmapped
    task automatic t_midreset;
        resetn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        rd_chk(sec, 32'h00a50000, okay);
        rd_chk(cfg_idx[1], 32'h0, okay);
    endtask : t_midreset
    // Frozen enable must stop the period count
    task automatic t_freeze;
        wr_chk(sec, 32'h00420000, 4'h4, okay);
        clk_en <= 1'b0;
        repeat (40) @(posedge clk_sys);
        clk_en <= 1'b1;
        rd_chk(sec, 32'h00420000, okay);
    endtask : t_freeze
    task automatic give_verdict;
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------------
    // Run
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        err_count = 0;
        n_tests = 0;
        resetn = 1'b0;
        clk_en = 1'b1;
        chk_int_en = 1'b0;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_unlocked();
        t_lock(1'b1, 8'h3c);
        t_unlock();
        t_lock(1'b0, 8'h00);
        t_unmapped();
        t_midreset();
        t_freeze();
        give_verdict();
    end
    // Watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        repeat (5000) @(posedge clk_sys);
        err_count++;
        give_verdict();
    end
endmodule : tb_top
